// file: wdc_top.sv
// Purpose: watchdog timer control with apb register access
// Assumes: osc_tick is one pclk pulse per oscillator cycle, already synchronous
// Notes:   pready is always high; prdata is captured in the setup cycle
// Operation
// - time-out in an interrupt mode sets timeout_irq_flag, bit 7.
// - flag clears on vector taken or software writing one to it.
// - interrupt request needs global enable and timeout_irq_enable both set.
// - combined mode: first time-out sets flag; vector clears enable and flag.
// - combined mode: second time-out with flag pending gives system reset.
// - unprogrammed always-on: reset/irq enable pair selects stopped/irq/reset/both.
// - programmed always-on forces system reset mode whatever the bits.
// - clearing reset enable or changing period needs change_unlock set.
// - change_unlock clears itself four system clock cycles after set.
// - reset enable held at one while reset cause flag is set.
// - time-out length is 2048 times two to the period code.
// - period_select msb at bit 5, low three bits at 2:0.
// - counter advances on ticks of the separate slow oscillator.
// - restart instruction zeroes the counter; software restarts before time-out.
`timescale 1ns/1ps
`include "wdc_params.svh"
module wdc_top #(
  parameter int unsigned ADDR_W = 12
) (
  // apb slave
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // processor and reset unit side
  input  wire logic              osc_tick,
  input  wire logic              wdt_restart,
  input  wire logic              irq_vector_ack,
  input  wire logic              global_irq_enable,
  input  wire logic              always_on_setting_n,
  input  wire logic              watchdog_reset_cause_flag,
  // requests out
  output logic                   timeout_irq_req,
  output logic                   sys_reset_req,
  output logic                   irq
);
  wdc_pkg::wdc_ctl_s  s_q;
  wdc_pkg::wdc_ctl_s  s_d;
  wdc_pkg::wdc_mode_e mode;
  wdc_cnt_if          cif ();

  logic       acc;
  logic       wr_ctrl;
  logic       wr_sts;
  logic       wr_msk;
  logic       hit;
  logic [7:0] wd;
  logic       wde_eff;
  logic       ie_eff;
  logic       set_flag;
  logic       rst_evt;
  logic [7:0] ctrl_rd;
  logic [31:0] rd;

  // apb decode, writes land in the access cycle only
  always_comb begin
    acc     = psel && penable;
    hit     = (paddr == `WDC_CTRL_OFS) || (paddr == `WDC_STATUS_OFS) ||
              (paddr == `WDC_MASK_OFS);
    wr_ctrl = acc && pwrite && (paddr == `WDC_CTRL_OFS);
    wr_sts  = acc && pwrite && (paddr == `WDC_STATUS_OFS);
    wr_msk  = acc && pwrite && (paddr == `WDC_MASK_OFS);
    wd      = pwdata[7:0];
  end

  // programmed always-on locks reset enable to 1 and irq enable to 0
  always_comb begin
    wde_eff = s_q.system_reset_enable || !always_on_setting_n;
    ie_eff  = s_q.ie && always_on_setting_n;
    mode    = wdc_pkg::wdc_mode_e'({wde_eff, ie_eff});
  end

  // time-out action by mode
  always_comb begin
    set_flag = 1'b0;
    rst_evt  = 1'b0;
    if (cif.timeout) begin
      unique case (mode)
        wdc_pkg::WDC_STOPPED:  begin
        end
        wdc_pkg::WDC_IRQ_ONLY: begin
          set_flag = 1'b1;
        end
        wdc_pkg::WDC_IRQ_RST:  begin
          // unserviced flag means the handler never ran: reset instead
          if (s_q.flag) begin
            rst_evt = 1'b1;
          end else begin
            set_flag = 1'b1;
          end
        end
        wdc_pkg::WDC_RST_ONLY: begin
          rst_evt = 1'b1;
        end
      endcase
    end
  end

  // read view of watchdog_control, period split across bits 5 and 2:0
  always_comb begin
    ctrl_rd = 8'h00;
    ctrl_rd[`WDC_FLAG_BIT]        = s_q.flag;
    ctrl_rd[`WDC_IE_BIT]          = ie_eff;
    ctrl_rd[`WDC_WDP3_BIT]        = s_q.wdp[3];
    ctrl_rd[`WDC_UNLOCK_BIT]      = s_q.unlock;
    ctrl_rd[`WDC_WDE_BIT]         = wde_eff;
    ctrl_rd[`WDC_WDP_LO_MSB -: 3] = s_q.wdp[2:0];
    unique case (paddr)
      `WDC_CTRL_OFS:   rd = {24'h000000, ctrl_rd};
      `WDC_STATUS_OFS: rd = {30'h00000000, s_q.sts};
      `WDC_MASK_OFS:   rd = {30'h00000000, s_q.msk};
      default:         rd = 32'h00000000;
    endcase
  end

  // next state of all control registers
  always_comb begin
    s_d         = s_q;
    s_d.rst_req = rst_evt;
    if (psel && !penable) begin
      s_d.prdata = rd;
    end
    // change_unlock window runs down, a new unlock write re-arms it
    if (s_q.ucnt != `WDC_UNLOCK_RST) begin
      s_d.ucnt = s_q.ucnt - 3'h1;
    end
    if (s_q.ucnt == 3'h1) begin
      s_d.unlock = 1'b0;
    end
    if (wr_ctrl) begin
      s_d.ie = wd[`WDC_IE_BIT];
      // setting reset enable is always allowed, clearing is protected
      if (wd[`WDC_WDE_BIT]) begin
        s_d.system_reset_enable = 1'b1;
      end else if (s_q.unlock) begin
        s_d.system_reset_enable = 1'b0;
      end
      if (s_q.unlock) begin
        s_d.wdp = {wd[`WDC_WDP3_BIT], wd[`WDC_WDP_LO_MSB -: 3]};
      end
      if (wd[`WDC_UNLOCK_BIT]) begin
        s_d.unlock = 1'b1;
        s_d.ucnt   = `WDC_UNLOCK_CYCLES;
      end
    end
    // handler entry in combined mode falls back to pure reset mode
    if (irq_vector_ack && s_q.flag && mode == wdc_pkg::WDC_IRQ_RST) begin
      s_d.ie = 1'b0;
    end
    if (watchdog_reset_cause_flag) begin
      s_d.system_reset_enable = 1'b1;
    end
    // flag: clears by vector or write-one, a same-cycle set_flag wins
    s_d.flag = (s_q.flag && !(irq_vector_ack || (wr_ctrl && wd[`WDC_FLAG_BIT]))) ||
               set_flag;
    // sticky event bits, write one to clear, set wins
    s_d.sts = (s_q.sts & ~(wr_sts ? wd[1:0] : 2'h0)) | {rst_evt, set_flag};
    if (wr_msk) begin
      s_d.msk = wd[1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q        <= '0;
      s_q.wdp    <= `WDC_WDP_RST;
      s_q.msk    <= `WDC_MASK_RST;
      s_q.ucnt   <= `WDC_UNLOCK_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // counter link
  assign cif.tick    = osc_tick;
  assign cif.restart = wdt_restart;
  assign cif.run     = mode != wdc_pkg::WDC_STOPPED;
  assign cif.period  = s_q.wdp;

  wdc_counter wdc_counter_i (
    .pclk    (pclk),
    .presetn (presetn),
    .cif     (cif)
  );

  // outputs
  assign prdata          = s_q.prdata;
  assign pready          = 1'b1;
  assign pslverr         = acc && !hit;
  assign timeout_irq_req = s_q.flag && ie_eff && global_irq_enable;
  assign sys_reset_req   = s_q.rst_req;
  assign irq             = |(s_q.sts & s_q.msk);

  property p_irq_sets_flag;
    @(posedge pclk) disable iff (!presetn)
      (cif.timeout && mode == wdc_pkg::WDC_IRQ_ONLY) |=> s_q.flag;
  endproperty
  a_irq_sets_flag: assert property (p_irq_sets_flag)
    else $error("interrupt-mode time-out did not set the flag");

  property p_flag_clear;
    @(posedge pclk) disable iff (!presetn)
      ((irq_vector_ack || (wr_ctrl && wd[`WDC_FLAG_BIT])) && !cif.timeout) |=> !s_q.flag;
  endproperty
  a_flag_clear: assert property (p_flag_clear)
    else $error("flag not cleared by vector or write-one");

  property p_req_gated;
    @(posedge pclk) disable iff (!presetn)
      timeout_irq_req |-> global_irq_enable && s_q.ie && always_on_setting_n && s_q.flag;
  endproperty
  a_req_gated: assert property (p_req_gated)
    else $error("interrupt request without both enables");

  property p_combined_ack;
    @(posedge pclk) disable iff (!presetn)
      (mode == wdc_pkg::WDC_IRQ_RST && s_q.flag && irq_vector_ack && !cif.timeout)
        |=> !s_q.ie && !s_q.flag;
  endproperty
  a_combined_ack: assert property (p_combined_ack)
    else $error("vector in combined mode left enable or flag set");

  property p_second_timeout;
    @(posedge pclk) disable iff (!presetn)
      (mode == wdc_pkg::WDC_IRQ_RST && s_q.flag && cif.timeout) |=> sys_reset_req ##1 !sys_reset_req;
  endproperty
  a_second_timeout: assert property (p_second_timeout)
    else $error("second time-out did not give one reset pulse");

  property p_always_on;
    @(posedge pclk) disable iff (!presetn)
      (!always_on_setting_n && cif.timeout) |=> sys_reset_req && !$rose(s_q.flag);
  endproperty
  a_always_on: assert property (p_always_on)
    else $error("always-on time-out did not reset");

  property p_protected;
    @(posedge pclk) disable iff (!presetn)
      (wr_ctrl && !s_q.unlock) |=> $stable(s_q.wdp) && (s_q.system_reset_enable || !$past(s_q.system_reset_enable));
  endproperty
  a_protected: assert property (p_protected)
    else $error("protected field changed while locked");

  property p_unlock_window;
    @(posedge pclk) disable iff (!presetn)
      (wr_ctrl && wd[`WDC_UNLOCK_BIT]) ##1 !(wr_ctrl && wd[`WDC_UNLOCK_BIT]) [*4]
        |=> !s_q.unlock;
  endproperty
  a_unlock_window: assert property (p_unlock_window)
    else $error("change_unlock outlived four cycles");

  property p_unlock_held;
    @(posedge pclk) disable iff (!presetn)
      (wr_ctrl && wd[`WDC_UNLOCK_BIT]) |=> s_q.unlock [*4];
  endproperty
  a_unlock_held: assert property (p_unlock_held)
    else $error("change_unlock dropped early");

  property p_cause_holds_wde;
    @(posedge pclk) disable iff (!presetn)
      watchdog_reset_cause_flag |=> s_q.system_reset_enable;
  endproperty
  a_cause_holds_wde: assert property (p_cause_holds_wde)
    else $error("reset enable cleared while cause flag set");

  // reset-only mode asks for reset and never raises the flag
  property p_reset_only;
    @(posedge pclk) disable iff (!presetn)
      (mode == wdc_pkg::WDC_RST_ONLY && cif.timeout) |=> sys_reset_req && !$rose(s_q.flag);
  endproperty
  a_reset_only: assert property (p_reset_only)
    else $error("reset-only time-out did not give a reset");

  // stopped mode: a late time-out pulse must leave no trace
  property p_stopped_quiet;
    @(posedge pclk) disable iff (!presetn)
      (mode == wdc_pkg::WDC_STOPPED) |=> !sys_reset_req && !$rose(s_q.flag);
  endproperty
  a_stopped_quiet: assert property (p_stopped_quiet)
    else $error("stopped mode gave a reset or a flag");

  // unlocked write takes the split period field as written on the bus
  property p_period_split;
    @(posedge pclk) disable iff (!presetn)
      (wr_ctrl && s_q.unlock) |=>
        s_q.wdp == {$past(pwdata[`WDC_WDP3_BIT]), $past(pwdata[`WDC_WDP_LO_MSB -: 3])};
  endproperty
  a_period_split: assert property (p_period_split)
    else $error("period field not taken from bits 5 and 2:0");

  // a new flag always leaves its sticky event bit behind
  property p_flag_event;
    @(posedge pclk) disable iff (!presetn)
      $rose(s_q.flag) |-> s_q.sts[`WDC_EVT_TIMEOUT];
  endproperty
  a_flag_event: assert property (p_flag_event)
    else $error("flag set without its event bit");

  // setting reset enable needs no unlock, only clearing is guarded
  property p_wde_set;
    @(posedge pclk) disable iff (!presetn)
      (wr_ctrl && wd[`WDC_WDE_BIT]) |=> s_q.system_reset_enable;
  endproperty
  a_wde_set: assert property (p_wde_set)
    else $error("write of one to reset enable was lost");
endmodule : wdc_top

// file: wdc_params.svh
// Purpose: constants of the watchdog control block
// Assumes: included by bare name from the package and the design modules
// Notes:   offsets are byte addresses on the apb port, data in the low byte
`ifndef WDC_PARAMS_SVH
`define WDC_PARAMS_SVH

// register byte offsets
`define WDC_CTRL_OFS      12'h000
`define WDC_STATUS_OFS    12'h004
`define WDC_MASK_OFS      12'h008

// watchdog_control field positions
`define WDC_FLAG_BIT      7
`define WDC_IE_BIT        6
`define WDC_WDP3_BIT      5
`define WDC_UNLOCK_BIT    4
`define WDC_WDE_BIT       3
`define WDC_WDP_LO_MSB    2

// event status field positions
`define WDC_EVT_TIMEOUT   0
`define WDC_EVT_RESET     1

// reset values
`define WDC_WDP_RST       4'h0
`define WDC_MASK_RST      2'h0
`define WDC_UNLOCK_RST    3'h0

// change_unlock stays open this many system clock cycles
`define WDC_UNLOCK_CYCLES 3'h4

// time-out length: 2^(base + code) oscillator cycles, codes up to the max
`define WDC_BASE_LOG2     11
`define WDC_MAX_CODE      4'h9

`endif

// file: wdc_pkg.sv
// Purpose: types shared by the watchdog control modules
// Assumes: wdc_params.svh holds every number
// Notes:   state of each module is one packed struct
package wdc_pkg;
  `include "wdc_params.svh"

  // counter width covers the longest time-out
  localparam int unsigned CNT_W = `WDC_BASE_LOG2 + int'(`WDC_MAX_CODE) + 1;

  // mode from {system_reset_enable, timeout_irq_enable}, gray along 00-01-11
  typedef enum logic [1:0] {
    WDC_STOPPED  = 2'h0,
    WDC_IRQ_ONLY = 2'h1,
    WDC_IRQ_RST  = 2'h3,
    WDC_RST_ONLY = 2'h2
  } wdc_mode_e;

  typedef struct packed {
    logic              flag;
    logic              ie;
    logic              system_reset_enable;
    logic [3:0]        wdp;
    logic              unlock;
    logic [2:0]        ucnt;
    logic [1:0]        sts;
    logic [1:0]        msk;
    logic              rst_req;
    logic [31:0]       prdata;
  } wdc_ctl_s;

  typedef struct packed {
    logic [CNT_W-1:0]  cnt;
    logic              timeout;
  } wdc_cnt_s;
endpackage : wdc_pkg

// file: wdc_cnt_if.sv
// Purpose: carrier between control logic and the oscillator counter
// Assumes: one clock domain, tick is a one-cycle pulse per oscillator cycle
// Notes:   timeout is a one-cycle pulse from a flip-flop
`timescale 1ns/1ps
interface wdc_cnt_if;
  logic       tick;
  logic       restart;
  logic       run;
  logic [3:0] period;
  logic       timeout;

  modport ctl (output tick, output restart, output run, output period, input timeout);
  modport cnt (input tick, input restart, input run, input period, output timeout);
endinterface : wdc_cnt_if

// file: wdc_counter.sv
// Purpose: watchdog_counter, counts oscillator ticks up to the selected period
// Assumes: tick and restart are synchronous one-cycle pulses
// Notes:   reserved period codes behave as the longest period
`timescale 1ns/1ps
`include "wdc_params.svh"
module wdc_counter #(
  parameter int unsigned BASE_LOG2 = `WDC_BASE_LOG2,
  parameter logic [3:0]  MAX_CODE  = `WDC_MAX_CODE
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // link to control logic
  wdc_cnt_if.cnt   cif
);
  localparam int unsigned W = wdc_pkg::CNT_W;

  wdc_pkg::wdc_cnt_s s_q;
  wdc_pkg::wdc_cnt_s s_d;
  logic [3:0]        code;
  logic [W-1:0]      last;

  // clamp reserved codes, terminal count is one below the length
  always_comb begin
    code = (cif.period > MAX_CODE) ? MAX_CODE : cif.period;
    last = (W'(1) << (BASE_LOG2 + 32'(code))) - W'(1);
  end

  // count on oscillator ticks only; >= catches a shortened period at once
  always_comb begin
    s_d         = s_q;
    s_d.timeout = 1'b0;
    if (cif.restart || !cif.run) begin
      s_d.cnt = '0;
    end else if (cif.tick) begin
      if (s_q.cnt >= last) begin
        s_d.cnt     = '0;
        s_d.timeout = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt + W'(1);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign cif.timeout = s_q.timeout;

  property p_restart_zero;
    @(posedge pclk) disable iff (!presetn) cif.restart |=> s_q.cnt == '0;
  endproperty
  a_restart_zero: assert property (p_restart_zero)
    else $error("counter not zero after restart");

  property p_tick_only;
    @(posedge pclk) disable iff (!presetn)
      (cif.run && !cif.restart && !cif.tick) |=> $stable(s_q.cnt) && !s_q.timeout;
  endproperty
  a_tick_only: assert property (p_tick_only)
    else $error("counter moved without an oscillator tick");

  property p_timeout_at_last;
    @(posedge pclk) disable iff (!presetn)
      s_q.timeout |-> $past(cif.tick) && $past(s_q.cnt) >= $past(last) && s_q.cnt == '0;
  endproperty
  a_timeout_at_last: assert property (p_timeout_at_last)
    else $error("time-out not at the selected terminal count");
endmodule : wdc_counter

// file: tb_wdc_top.sv
// Purpose: self-checking bench for the watchdog control block over apb
// Assumes: osc_tick held high after reset, so the counter advances every pclk
// Notes:   every wait is a bounded loop; a spent bound ends the run as a failure
`timescale 1ns/1ps
module tb_wdc_top;
  // design signals
  logic        pclk, presetn, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr, osc_tick, wdt_restart, irq_vector_ack;
  logic        global_irq_enable, always_on_setting_n, watchdog_reset_cause_flag;
  logic        timeout_irq_req, sys_reset_req, irq;
  // bench state
  int          err_count, num_checks, n;
  logic [31:0] rd;
  logic        er;

  wdc_top wdc_top_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .osc_tick(osc_tick), .wdt_restart(wdt_restart), .irq_vector_ack(irq_vector_ack),
    .global_irq_enable(global_irq_enable), .always_on_setting_n(always_on_setting_n),
    .watchdog_reset_cause_flag(watchdog_reset_cause_flag),
    .timeout_irq_req(timeout_irq_req), .sys_reset_req(sys_reset_req), .irq(irq)
  );

  // 40 mhz clock
  always #12.5 pclk = ~pclk;

  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // one apb transfer; starts at the next edge so no signal is driven twice per step
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    @(posedge pclk);
    while (pready !== 1'b1 && k < 50) begin
      k++;
      @(posedge pclk);
    end
    if (pready !== 1'b1) begin
      chk("pready", 32'h1, 32'h0);
      end_sim();
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdc(input logic [11:0] a, input logic [31:0] e, input string w);
    apb(1'b0, a, 32'h0);
    chk(w, e, rd);
  endtask : rdc

  // protected change: open the lock with wde set, then the new value at once
  task automatic unl(input logic [31:0] v);
    apb(1'b1, 12'h000, 32'h18);
    apb(1'b1, 12'h000, v);
  endtask : unl

  // sel 0 restart, 1 vector taken
  task automatic pulse(input int sel);
    @(posedge pclk);
    if (sel == 0) wdt_restart <= 1'b1; else irq_vector_ack <= 1'b1;
    @(posedge pclk);
    wdt_restart    <= 1'b0;
    irq_vector_ack <= 1'b0;
  endtask : pulse

  // sel 0 timeout_irq_req, 1 sys_reset_req, 2 irq; n counts edges waited
  task automatic wait_on(input int sel, input int bound);
    logic s;
    n = 0;
    s = 1'b0;
    while (s !== 1'b1) begin
      @(posedge pclk);
      #1;
      n++;
      s = (sel == 0) ? timeout_irq_req : (sel == 1) ? sys_reset_req : irq;
      if (n >= bound && s !== 1'b1) begin
        chk("wait_on", 32'h1, 32'h0);
        end_sim();
      end
    end
  endtask : wait_on

  task automatic t_reset();
    rdc(12'h000, 32'h0, "ctrl_rst");
    rdc(12'h004, 32'h0, "status_rst");
    rdc(12'h008, 32'h0, "mask_rst");
    rdc(12'h00c, 32'h0, "unmapped_rd");
    chk("unmapped_err", 32'h1, er);
    $display("test reset done");
  endtask : t_reset

  // interrupt mode, restart mid-count, mask, global enable, write-one clear
  task automatic t_irq();
    apb(1'b1, 12'h008, 32'h1);
    apb(1'b1, 12'h000, 32'h40);
    repeat (1000) @(posedge pclk);
    pulse(0);
    wait_on(2, 2200);
    chk("restart_len", 32'h1, n >= 2044 && n <= 2056);
    chk("req_gie_off", 32'h0, timeout_irq_req);
    rdc(12'h000, 32'hc0, "flag_set");
    apb(1'b1, 12'h008, 32'h0);
    @(posedge pclk);
    global_irq_enable <= 1'b1;
    #1;
    chk("irq_masked", 32'h0, irq);
    chk("req_gie_on", 32'h1, timeout_irq_req);
    apb(1'b1, 12'h000, 32'hc0);
    rdc(12'h000, 32'h40, "flag_w1c");
    chk("req_cleared", 32'h0, timeout_irq_req);
    apb(1'b1, 12'h000, 32'h00);
    apb(1'b1, 12'h004, 32'h3);
    rdc(12'h004, 32'h0, "status_w1c");
    $display("test irq mode done");
  endtask : t_irq

  // combined mode: ack drops to reset mode, re-arm, then unserviced second time-out
  task automatic t_comb();
    apb(1'b1, 12'h000, 32'h48);
    wait_on(0, 2200);
    pulse(1);
    rdc(12'h000, 32'h08, "ack_clears");
    apb(1'b1, 12'h000, 32'h48);
    wait_on(0, 2200);
    wait_on(1, 2200);
    chk("second_len", 32'h1, n >= 2044 && n <= 2056);
    rdc(12'h004, 32'h3, "events");
    apb(1'b1, 12'h004, 32'h3);
    apb(1'b1, 12'h000, 32'h88);
    rdc(12'h000, 32'h08, "rst_only");
    wait_on(1, 2200);
    chk("rst_only_req", 32'h0, timeout_irq_req);
    $display("test combined mode done");
  endtask : t_comb

  // locked writes, lock expiry, split period field
  task automatic t_lock();
    apb(1'b1, 12'h000, 32'h00);
    rdc(12'h000, 32'h08, "locked_wde");
    apb(1'b1, 12'h000, 32'h0f);
    rdc(12'h000, 32'h08, "locked_wdp");
    apb(1'b1, 12'h000, 32'h18);
    repeat (4) @(posedge pclk);
    apb(1'b1, 12'h000, 32'h00);
    rdc(12'h000, 32'h08, "lock_expired");
    unl(32'h29);
    rdc(12'h000, 32'h29, "wdp_split");
    unl(32'h01);
    rdc(12'h000, 32'h01, "wde_cleared");
    $display("test lock done");
  endtask : t_lock

  task automatic t_per1();
    apb(1'b1, 12'h008, 32'h1);
    apb(1'b1, 12'h000, 32'h41);
    wait_on(2, 4400);
    chk("code1_len", 32'h1, n >= 4094 && n <= 4104);
    apb(1'b1, 12'h000, 32'h81);
    rdc(12'h000, 32'h01, "stopped");
    apb(1'b1, 12'h004, 32'h3);
    $display("test period done");
  endtask : t_per1

  // reset cause holds wde; always-on forces reset mode
  task automatic t_force();
    @(posedge pclk);
    watchdog_reset_cause_flag <= 1'b1;
    rdc(12'h000, 32'h09, "cause_wde");
    unl(32'h01);
    rdc(12'h000, 32'h09, "cause_hold");
    @(posedge pclk);
    watchdog_reset_cause_flag <= 1'b0;
    unl(32'h00);
    rdc(12'h000, 32'h00, "cause_gone");
    @(posedge pclk);
    always_on_setting_n <= 1'b0;
    pulse(0);
    wait_on(1, 2200);
    chk("aon_no_req", 32'h0, timeout_irq_req);
    rdc(12'h000, 32'h08, "aon_wde");
    $display("test forced modes done");
  endtask : t_force

  // reset in mid-run: events and mask drop back, forced reset mode stays
  task automatic t_midrst();
    rdc(12'h004, 32'h2, "status_pre");
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rdc(12'h004, 32'h0, "status_rerst");
    rdc(12'h008, 32'h0, "mask_rerst");
    rdc(12'h000, 32'h08, "aon_rerst");
    $display("test mid-run reset done");
  endtask : t_midrst

  // reset, then scenarios in order
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {osc_tick, wdt_restart, irq_vector_ack, global_irq_enable} = '0;
    always_on_setting_n = 1'b1;
    watchdog_reset_cause_flag = 1'b0;
    err_count = 0;
    num_checks = 0;
    repeat (5) @(posedge pclk);
    presetn  <= 1'b1;
    osc_tick <= 1'b1;
    t_reset();
    t_irq();
    t_comb();
    t_lock();
    t_per1();
    t_force();
    t_midrst();
    end_sim();
  end
endmodule : tb_wdc_top
